// file: adcs_pkg.sv
// Package of constants and types for the converter sequencer.
// Behaviour
// - A conversion lasts exactly eleven bit periods once converting starts.
// - Clock select picks 2,4,8,16,32,64 oscillator periods, or RC for x11.
// - Clearing go/done mid-conversion aborts it; result registers stay unchanged.
// - Result pair holds last completed non-calibration conversion or last software write.
// - After completion or abort wait two bit periods, then resume acquisition.
// - Acquisition code 010 samples four bit periods before converting.
// - Acquisition code 000 delays conversion start one instruction cycle.
// - Capture mode 1011 trigger with converter on sets go/done, resets timer.
// - With converter off the trigger is ignored but still resets the timer.
// - Calibrate request makes next conversion a dummy stored as offset correction.
// - Sequencing ignores channel select and pin direction bits.
// - Port reads return zero for pins configured as analog inputs.
// - Completion loads result (offset on a calibration run), clears go/done and sets the done flag.
// - Acquisition codes 000..111 give 0,2,4,6,8,12,16,20 bit periods.
// - Justify bit set places result right, clear places it left.
package adcs_pkg;
   localparam logic [2:0] ADCS_ADDR_RES_HIGH = 3'h0;
   localparam logic [2:0] ADCS_ADDR_RES_LOW = 3'h1;
   localparam logic [2:0] ADCS_ADDR_CHAN_CTRL = 3'h2;
   localparam logic [2:0] ADCS_ADDR_REF_CFG = 3'h3;
   localparam logic [2:0] ADCS_ADDR_TIMING_CFG = 3'h4;
   localparam logic [2:0] ADCS_ADDR_STATUS = 3'h5;
   localparam logic [2:0] ADCS_ADDR_PORT = 3'h6;
   // Channel control fields, then the timing config justify bit.
   localparam int ADCS_BIT_CAL = 7;
   localparam int ADCS_BIT_GO = 1;
   localparam int ADCS_BIT_ON = 0;
   localparam int ADCS_BIT_JUSTIFY = 7;
   localparam logic [7:0] ADCS_CHAN_CTRL_MASK = 8'hbf;
   localparam logic [7:0] ADCS_REF_CFG_MASK = 8'h3f;
   localparam logic [7:0] ADCS_TIMING_CFG_MASK = 8'hbf;
   localparam logic [7:0] ADCS_RESET_VALUE = 8'h00;
   localparam logic [3:0] ADCS_TRIGGER_MODE = 4'hb;
   localparam logic [3:0] ADCS_CONV_PERIODS = 4'hb;
   localparam logic [3:0] ADCS_RECOVER_PERIODS = 4'h2;
   // One instruction cycle is four oscillator periods.
   localparam logic [7:0] ADCS_INSTR_CYCLES = 8'h04;
   // Internal RC bit period: 4 us typical at 125 MHz.
   localparam int ADCS_RC_PERIOD_NS = 4000;
   localparam int ADCS_CLK_NS = 8;
   localparam logic [9:0] ADCS_RC_CYCLES = 10'(ADCS_RC_PERIOD_NS / ADCS_CLK_NS);
   typedef enum logic [2:0] {ADCS_IDLE, ADCS_DELAY, ADCS_ACQ, ADCS_CONV, ADCS_RECOVER}
      adcs_state_t;
endpackage

// file: adcs_sar_model.sv
// Behavioural model of the analog sample-and-hold and SAR core.
`timescale 1ns/1ps
module adcs_sar_model
(
   input wire logic clk,
   input wire logic convert_active,
   input wire logic calibrate_active,
   input wire logic [9:0] level,
   input wire logic [9:0] dummy_level,
   output logic [9:0] sar_result = 10'h155
);
   // Outside a conversion the core holds no settled value, so the bits keep toggling.
   always_ff @(posedge clk)
   begin
      if (convert_active || calibrate_active)
         sar_result <= calibrate_active ? dummy_level : level;
      else
         sar_result <= ~sar_result;
   end
endmodule // adcs_sar_model

// file: adcs_sequencer.sv
// Converter sequencer with register port, timing and result handling.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module adcs_sequencer
   import adcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic special_event,
   input wire logic [3:0] capture_unit_mode_field,
   input wire logic [7:0] port_pins,
   input wire logic [7:0] analog_pin_mask,
   input wire logic [9:0] sar_result,
   output logic sample_enable,
   output logic convert_active,
   output logic calibrate_active,
   output logic conversion_done_flag,
   output logic time_base_reset
);
   logic [7:0] res_high_r, res_high_nxt;
   logic [7:0] res_low_r, res_low_nxt;
   logic [7:0] chan_ctrl_r, chan_ctrl_nxt;
   logic [7:0] ref_cfg_r, ref_cfg_nxt;
   logic [7:0] timing_cfg_r, timing_cfg_nxt;
   logic [9:0] offset_r, offset_nxt;
   logic cal_run_r, cal_run_nxt;
   logic done_r, done_nxt;
   logic tb_reset_r, tb_reset_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   adcs_state_t state_r, state_nxt;
   logic [4:0] count_r, count_nxt;
   logic [7:0] port_meta_r, port_sync_r;
   logic [9:0] corrected;
   logic [4:0] acq_periods;
   logic tick;
   logic converter_on;
   logic go;
   logic tick_run;

   assign converter_on = chan_ctrl_r[ADCS_BIT_ON];
   assign go = chan_ctrl_r[ADCS_BIT_GO];
   // Each phase change restarts the bit period counter, so the ACQ, CONV and RECOVER phases last whole periods.
   assign tick_run = converter_on && state_nxt == state_r;

   adcs_tick_gen u_tick
   (
      .clk(clk),
      .rst(rst),
      .enable(tick_run),
      .clock_select(timing_cfg_r[2:0]),
      .tick(tick)
   );

   always_comb
   begin
      unique case (timing_cfg_r[5:3])
         3'h0: acq_periods = 5'd0;
         3'h1: acq_periods = 5'd2;
         3'h2: acq_periods = 5'd4;
         3'h3: acq_periods = 5'd6;
         3'h4: acq_periods = 5'd8;
         3'h5: acq_periods = 5'd12;
         3'h6: acq_periods = 5'd16;
         default: acq_periods = 5'd20;
      endcase
   end

   assign corrected = sar_result - offset_r;

   always_comb
   begin
      res_high_nxt = res_high_r;
      res_low_nxt = res_low_r;
      chan_ctrl_nxt = chan_ctrl_r;
      ref_cfg_nxt = ref_cfg_r;
      timing_cfg_nxt = timing_cfg_r;
      offset_nxt = offset_r;
      cal_run_nxt = cal_run_r;
      state_nxt = state_r;
      count_nxt = count_r;
      done_nxt = 1'b0;
      tb_reset_nxt = 1'b0;
      if (wr)
      begin
         unique case (addr)
            ADCS_ADDR_RES_HIGH: res_high_nxt = wdata;
            ADCS_ADDR_RES_LOW: res_low_nxt = wdata;
            ADCS_ADDR_CHAN_CTRL: chan_ctrl_nxt = wdata & ADCS_CHAN_CTRL_MASK;
            ADCS_ADDR_REF_CFG: ref_cfg_nxt = wdata & ADCS_REF_CFG_MASK;
            ADCS_ADDR_TIMING_CFG: timing_cfg_nxt = wdata & ADCS_TIMING_CFG_MASK;
            default: ;
         endcase
      end
      if (special_event && capture_unit_mode_field == ADCS_TRIGGER_MODE)
      begin
         tb_reset_nxt = 1'b1;
         if (converter_on)
         begin
            chan_ctrl_nxt[ADCS_BIT_GO] = 1'b1;
         end
      end
      // Channel and pin direction never gate the sequence.
      unique case (state_r)
         ADCS_IDLE:
         begin
            if (go && converter_on)
            begin
               cal_run_nxt = chan_ctrl_r[ADCS_BIT_CAL];
               count_nxt = 5'd0;
               if (acq_periods == 5'd0)
               begin
                  state_nxt = ADCS_DELAY;
               end
               else
               begin
                  state_nxt = ADCS_ACQ;
               end
            end
         end
         ADCS_DELAY:
         begin
            count_nxt = count_r + 5'd1;
            if (count_r == 5'(ADCS_INSTR_CYCLES - 8'h01))
            begin
               count_nxt = 5'd0;
               state_nxt = ADCS_CONV;
            end
         end
         ADCS_ACQ:
         begin
            if (tick)
            begin
               count_nxt = count_r + 5'd1;
               if (count_r == acq_periods - 5'd1)
               begin
                  count_nxt = 5'd0;
                  state_nxt = ADCS_CONV;
               end
            end
         end
         ADCS_CONV:
         begin
            if (tick)
            begin
               count_nxt = count_r + 5'd1;
               if (count_r == 5'(ADCS_CONV_PERIODS) - 5'd1)
               begin
                  count_nxt = 5'd0;
                  state_nxt = ADCS_RECOVER;
                  chan_ctrl_nxt[ADCS_BIT_GO] = 1'b0;
                  done_nxt = 1'b1;
                  if (cal_run_r)
                  begin
                     offset_nxt = sar_result;
                     chan_ctrl_nxt[ADCS_BIT_CAL] = 1'b0;
                  end
                  else if (timing_cfg_r[ADCS_BIT_JUSTIFY])
                  begin
                     res_high_nxt = {6'h00, corrected[9:8]};
                     res_low_nxt = corrected[7:0];
                  end
                  else
                  begin
                     res_high_nxt = corrected[9:2];
                     res_low_nxt = {corrected[1:0], 6'h00};
                  end
               end
            end
         end
         ADCS_RECOVER:
         begin
            if (tick)
            begin
               count_nxt = count_r + 5'd1;
               if (count_r == 5'(ADCS_RECOVER_PERIODS) - 5'd1)
               begin
                  count_nxt = 5'd0;
                  state_nxt = ADCS_IDLE;
               end
            end
         end
      endcase
      // Go cleared or converter off during a run aborts without a result load.
      if (state_r != ADCS_IDLE && state_r != ADCS_RECOVER && (!go || !converter_on))
      begin
         state_nxt = ADCS_RECOVER;
         count_nxt = 5'd0;
         done_nxt = 1'b0;
         res_high_nxt = res_high_r;
         res_low_nxt = res_low_r;
         offset_nxt = offset_r;
      end
      if (!converter_on)
      begin
         state_nxt = ADCS_IDLE;
         count_nxt = 5'd0;
      end
   end

   always_comb
   begin
      rdata_nxt = 8'h00;
      if (rd)
      begin
         unique case (addr)
            ADCS_ADDR_RES_HIGH: rdata_nxt = res_high_r;
            ADCS_ADDR_RES_LOW: rdata_nxt = res_low_r;
            ADCS_ADDR_CHAN_CTRL: rdata_nxt = chan_ctrl_r;
            ADCS_ADDR_REF_CFG: rdata_nxt = ref_cfg_r;
            ADCS_ADDR_TIMING_CFG: rdata_nxt = timing_cfg_r;
            ADCS_ADDR_STATUS: rdata_nxt = {5'h00, state_r};
            ADCS_ADDR_PORT: rdata_nxt = port_sync_r & ~analog_pin_mask;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      port_meta_r <= port_pins;
      port_sync_r <= port_meta_r;
      if (rst)
      begin
         chan_ctrl_r <= ADCS_RESET_VALUE;
         ref_cfg_r <= ADCS_RESET_VALUE;
         timing_cfg_r <= ADCS_RESET_VALUE;
         state_r <= ADCS_IDLE;
         count_r <= 5'd0;
         cal_run_r <= 1'b0;
         done_r <= 1'b0;
         tb_reset_r <= 1'b0;
         rdata_r <= 8'h00;
      end
      else
      begin
         chan_ctrl_r <= chan_ctrl_nxt;
         ref_cfg_r <= ref_cfg_nxt;
         timing_cfg_r <= timing_cfg_nxt;
         state_r <= state_nxt;
         count_r <= count_nxt;
         cal_run_r <= cal_run_nxt;
         done_r <= done_nxt;
         tb_reset_r <= tb_reset_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Result pair survives reset, matching power-on behaviour; reset clears the offset to zero.
   always_ff @(posedge clk)
   begin
      res_high_r <= res_high_nxt;
      res_low_r <= res_low_nxt;
      offset_r <= rst ? 10'h000 : offset_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sample_enable <= 1'b0;
         convert_active <= 1'b0;
         calibrate_active <= 1'b0;
      end
      else
      begin
         sample_enable <= converter_on && (state_nxt == ADCS_IDLE || state_nxt == ADCS_ACQ);
         convert_active <= state_nxt == ADCS_CONV;
         calibrate_active <= state_nxt == ADCS_CONV && cal_run_nxt;
      end
   end

   assign rdata = rdata_r;
   assign conversion_done_flag = done_r;
   assign time_base_reset = tb_reset_r;
endmodule // adcs_sequencer

// file: adcs_sequencer_chk.sv
// Port assertions for the converter sequencer.
`timescale 1ns/1ps
module adcs_sequencer_chk
   import adcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic special_event,
   input wire logic [3:0] capture_unit_mode_field,
   input wire logic sample_enable,
   input wire logic convert_active,
   input wire logic calibrate_active,
   input wire logic conversion_done_flag,
   input wire logic time_base_reset
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   logic on_r, on_nxt;
   logic [1:0] gap_r, gap_nxt;
   always_comb
   begin
      on_nxt = (wr && addr == ADCS_ADDR_CHAN_CTRL) ? wdata[ADCS_BIT_ON] : on_r;
      gap_nxt = (convert_active || calibrate_active) ? 2'h0 : gap_r + {1'b0, gap_r != 2'h3};
   end
   always_ff @(posedge clk)
   begin
      on_r <= rst ? 1'b0 : on_nxt;
      gap_r <= rst ? 2'h3 : gap_nxt;
   end
   sequence trig_s;
      special_event && capture_unit_mode_field == ADCS_TRIGGER_MODE;
   endsequence
   trig_reset_a: assert property (trig_s |=> time_base_reset)
      else $error("no timer reset");
   timer_cause_a: assert property (time_base_reset |-> $past(special_event))
      else $error("stray timer reset");
   done_pulse_a: assert property (conversion_done_flag |=> !conversion_done_flag)
      else $error("done too long");
   done_cause_a: assert property (conversion_done_flag |-> gap_r != 2'h3)
      else $error("done without conversion");
   conv_hold_a: assert property ($rose(convert_active) |-> convert_active [*8])
      else $error("conversion too short");
   recover_wait_a: assert property ($fell(convert_active) |-> !sample_enable [*3])
      else $error("sampling too soon");
   phase_excl_a: assert property (!(sample_enable && convert_active))
      else $error("sampling while converting");
   off_idle_a: assert property (!on_r [*3] |-> !convert_active && !sample_enable)
      else $error("active while off");
endmodule // adcs_sequencer_chk

bind adcs_sequencer adcs_sequencer_chk chk_u (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .special_event(special_event),
   .capture_unit_mode_field(capture_unit_mode_field), .sample_enable(sample_enable),
   .convert_active(convert_active), .calibrate_active(calibrate_active),
   .conversion_done_flag(conversion_done_flag), .time_base_reset(time_base_reset));

// file: adcs_sequencer_test.sv
// Self-checking testbench for the converter sequencer.
`timescale 1ns/1ps
module adcs_sequencer_test
   import adcs_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic special_event = 1'b0;
   logic rd_d = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [3:0] mode = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] pins = 8'h00;
   logic [7:0] amask = 8'h00;
   logic [9:0] level = 10'h000;
   logic [9:0] dummy = 10'h003;
   logic [9:0] off = 10'h000;
   logic [15:0] seed = 16'h0041;
   logic [7:0] rdata, last_hi;
   logic [9:0] sar_result;
   logic sample_enable, convert_active, calibrate_active, done, tb_rst;
   logic [7:0] expq[$];
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int dones = 0;
   int n, d0;
   int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   adcs_sequencer dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .special_event(special_event), .capture_unit_mode_field(mode),
      .port_pins(pins), .analog_pin_mask(amask), .sar_result(sar_result),
      .sample_enable(sample_enable), .convert_active(convert_active),
      .calibrate_active(calibrate_active), .conversion_done_flag(done),
      .time_base_reset(tb_rst));
   adcs_sar_model sar_u (.clk(clk), .convert_active(convert_active),
      .calibrate_active(calibrate_active), .level(level), .dummy_level(dummy),
      .sar_result(sar_result));
   initial
      forever #4 clk = ~clk;
   function automatic logic [15:0] xs(input logic [15:0] s);
      logic [15:0] t;
      t = s ^ (s << 7);
      t = t ^ (t >> 9);
      return t ^ (t << 8);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [2:0] a, input logic [7:0] e);
      expq.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_for(ref logic s, input logic lvl, input int lim, output int k);
      k = 0;
      while (s !== lvl && k < lim)
      begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic pulse();
      special_event <= 1'b1;
      @(posedge clk);
      special_event <= 1'b0;
      @(posedge clk);
      check(8'(tb_rst), 8'h01);
   endtask
   task automatic conv(input logic [2:0] sel, input logic [2:0] acq, input logic just);
      int lat, div;
      logic [9:0] r;
      div = sel[1:0] == 2'h3 ? int'(ADCS_RC_CYCLES) : 2 << (2 * sel[1:0] + sel[2]);
      seed = xs(seed);
      level <= seed[9:0] | 10'h040;
      r = (seed[9:0] | 10'h040) - off;
      wait_for(sample_enable, 1'b1, 3000, lat);
      wreg(ADCS_ADDR_TIMING_CFG, {just, 1'b0, acq, sel});
      wreg(ADCS_ADDR_CHAN_CTRL, {2'h0, seed[13:10], 2'h3});
      wait_for(convert_active, 1'b1, 20000, lat);
      check(8'(lat + 2 >= acq_t[acq] * div && lat <= acq_t[acq] * div + div + 8), 8'h01);
      wait_for(convert_active, 1'b0, 40000, lat);
      check(8'(lat <= 11 * div && lat > 10 * div), 8'h01);
      wait_for(done, 1'b1, 4, lat);
      check(8'(lat < 4), 8'h01);
      last_hi = just ? {6'h00, r[9:8]} : r[9:2];
      rreg(ADCS_ADDR_RES_HIGH, last_hi);
      rreg(ADCS_ADDR_RES_LOW, just ? r[7:0] : {r[1:0], 6'h00});
      rreg(ADCS_ADDR_CHAN_CTRL, {2'h0, seed[13:10], 2'h1});
   endtask
   task automatic conclude();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      rd_d <= rd;
      if (done)
         dones <= dones + 1;
      if (rd_d)
         check(rdata, expq.pop_front());
      if (cycles == 60000)
      begin
         num_errors++;
         conclude();
      end
   end
   initial
   begin
      seed = xs(seed);
      pins <= seed[7:0];
      amask <= seed[15:8];
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rreg(ADCS_ADDR_CHAN_CTRL, 8'h00);
      rreg(ADCS_ADDR_TIMING_CFG, 8'h00);
      rreg(ADCS_ADDR_STATUS, {5'h00, ADCS_IDLE});
      wreg(ADCS_ADDR_REF_CFG, 8'hff);
      rreg(ADCS_ADDR_REF_CFG, ADCS_REF_CFG_MASK);
      wreg(3'h7, 8'hff);
      rreg(3'h7, 8'h00);
      wreg(ADCS_ADDR_RES_LOW, 8'h5a);
      rreg(ADCS_ADDR_RES_LOW, 8'h5a);
      rreg(ADCS_ADDR_PORT, pins & ~amask);
      $display("register test done");
      wreg(ADCS_ADDR_CHAN_CTRL, 8'h01);
      for (int i = 0; i < 8; i++)
         conv(3'(i), 3'(i), i[0]);
      $display("timing test done");
      wait_for(sample_enable, 1'b1, 3000, n);
      wreg(ADCS_ADDR_TIMING_CFG, 8'h82);
      level <= ~level;
      wreg(ADCS_ADDR_CHAN_CTRL, 8'h03);
      wait_for(convert_active, 1'b1, 100, n);
      repeat (50) @(posedge clk);
      d0 = dones;
      wreg(ADCS_ADDR_CHAN_CTRL, 8'h01);
      repeat (300) @(posedge clk);
      check(8'(dones - d0), 8'h00);
      rreg(ADCS_ADDR_RES_HIGH, last_hi);
      $display("abort test done");
      mode <= ADCS_TRIGGER_MODE;
      wait_for(sample_enable, 1'b1, 3000, n);
      pulse();
      wait_for(convert_active, 1'b1, 100, n);
      check(8'(n < 100), 8'h01);
      wait_for(done, 1'b1, 1000, n);
      check(8'(n < 1000), 8'h01);
      wreg(ADCS_ADDR_CHAN_CTRL, 8'h00);
      pulse();
      wait_for(convert_active, 1'b1, 100, n);
      check(8'(n), 8'h64);
      $display("trigger test done");
      wreg(ADCS_ADDR_CHAN_CTRL, 8'h81);
      wait_for(sample_enable, 1'b1, 3000, n);
      wreg(ADCS_ADDR_CHAN_CTRL, 8'h83);
      wait_for(calibrate_active, 1'b1, 100, n);
      check(8'(n < 100), 8'h01);
      wait_for(calibrate_active, 1'b0, 1000, n);
      off = dummy;
      rreg(ADCS_ADDR_CHAN_CTRL, 8'h01);
      conv(3'h0, 3'h1, 1'b1);
      $display("calibration test done");
      conclude();
   end
endmodule // adcs_sequencer_test

// file: adcs_tick_gen.sv
// Bit period tick generator for the converter sequencer.
`timescale 1ns/1ps
module adcs_tick_gen
   import adcs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [2:0] clock_select,
   output logic tick
);
   logic [9:0] count_r;
   logic [9:0] count_nxt;
   logic [9:0] limit;
   logic tick_nxt;

   always_comb
   begin
      unique case (clock_select)
         3'h0: limit = 10'h001;
         3'h4: limit = 10'h003;
         3'h1: limit = 10'h007;
         3'h5: limit = 10'h00f;
         3'h2: limit = 10'h01f;
         3'h6: limit = 10'h03f;
         default: limit = ADCS_RC_CYCLES - 10'h001;
      endcase
      tick_nxt = 1'b0;
      count_nxt = count_r + 10'h001;
      if (!enable)
      begin
         // Restarting at one puts the first tick a full bit period after a phase begins.
         count_nxt = 10'h001;
      end
      else if (count_r >= limit)
      begin
         count_nxt = 10'h000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_r <= 10'h000;
         tick <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         tick <= tick_nxt;
      end
   end
endmodule // adcs_tick_gen
